// ### ck_gen.sv
`timescale 1ns/1ps
`default_nettype none
// Divides the controller clock into the link clock
module ck_gen
  import mrw_ctrl_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_in,
  ck_if.gen         ck,
  output logic      ck_out
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       lvl;
  } st_s;

  st_s st_q;
  st_s st_d;

  // Clock stops low while run is low
  always_comb begin
    st_d = st_q;
    if (!ck.run) begin
      st_d.cnt = '0;
      st_d.lvl = 1'b0;
    end else if (st_q.cnt == CK_HALF - 4'h1) begin
      st_d.cnt = '0;
      st_d.lvl = ~st_q.lvl;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Launch strobes sit mid-phase, half a phase ahead of each link edge,
  // so the command lines settle well before the device samples them
  localparam logic [3:0] LAUNCH_AT = (CK_HALF >> 1) - 4'h1;
  assign ck.rise = ck.run && st_q.cnt == LAUNCH_AT && !st_q.lvl;
  assign ck.fall = ck.run && st_q.cnt == LAUNCH_AT && st_q.lvl;
  assign ck_out  = st_q.lvl;
endmodule
`default_nettype wire

// ### ck_if.sv
`timescale 1ns/1ps
`default_nettype none
// Link clock edge strobes between the divider and the sequencer
interface ck_if;
  logic rise;
  logic fall;
  logic run;
  modport gen (input run, output rise, output fall);
  modport use_ck (output run, input rise, input fall);
endinterface
`default_nettype wire

// ### mem_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural memory device: decodes mode writes and tracks power-down
module mem_dev_model
  import mrw_ctrl_pkg::*;
#(
  parameter logic [7:0] RO_LAST     = 8'h08,
  parameter bit         ZQ_STRAPPED = 1'b0
)
(
  input  wire logic        ck_in,
  input  wire logic        cke_in,
  input  wire logic        cs_n_in,
  input  wire logic [9:0]  ca_in,
  input  wire logic        banks_idle_in,
  output logic [15:0]      cmd_out,
  output logic             cmd_tgl_out,
  output logic             pd_out,
  output logic             pd_active_out,
  output logic             zq_on_out
);
  logic [7:0] mr [256];
  logic       hit;
  logic       cke_prev;
  logic [5:0] ma_lo;
  logic [7:0] ma;

  initial begin
    cmd_out = 16'h0000;
    cmd_tgl_out = 1'b0;
    pd_out = 1'b0;
    pd_active_out = 1'b0;
    zq_on_out = 1'b0;
    hit = 1'b0;
    cke_prev = 1'b1;
  end

  // Rising edge: command code, low address bits, power-down state
  always @(posedge ck_in) begin
    hit <= cke_in && cke_prev && !cs_n_in && ca_in[3:0] == 4'h0;
    ma_lo <= ca_in[9:4];
    if (!cs_n_in) zq_on_out <= 1'b0;
    if (!cke_in && cs_n_in && !pd_out) begin
      pd_out <= 1'b1;
      pd_active_out <= !banks_idle_in;
    end else if (cke_in && pd_out) begin
      pd_out <= 1'b0;
    end
    cke_prev <= cke_in;
  end

  // Falling edge: high address bits and data; read-only places ignore writes, a reset write clears every place
  always @(negedge ck_in) begin
    if (hit) begin
      ma = {ca_in[1:0], ma_lo};
      cmd_out <= {ma, ca_in[9:2]};
      cmd_tgl_out <= !cmd_tgl_out;
      if (ma == MA_RESET) begin
        for (int i = 0; i < 256; i++) mr[i] <= 8'h00;
      end else if (ma == MA_ZQ_CAL) begin
        zq_on_out <= !ZQ_STRAPPED && ca_in[9:2] != ZQ_OP_RESET;
      end else if (ma > RO_LAST) begin
        mr[ma] <= ca_in[9:2];
      end
    end
  end
endmodule
`default_nettype wire

// ### mrw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Rules kept by this block or the device model, unless noted
// (RL1) Mode write: chip select, CA3..CA0 low
// (RL2) Address and data split over both edges
// (RL3) Device ignores writes to read-only registers
// (RL4) Mode writes only with all banks idle
// (RL5) Only no-operations during mode write period
// (RL6) Device accepts mode reads idle or active; the device model decodes mode writes only
// (RL7) Reset write: no-operations, then boot timings
// (RL8) Four calibration commands to register 0Ah
// (RL9) Calibrate only when idle and precharged
// (RL10) Data bus quiet during long calibrations
// (RL11) CKE high, no-operations through calibration
// (RL12) Shared resistor: calibrations never overlap
// (RL13) Device ignores calibration when pin strapped
// (RL14) Device disables calibration pin afterwards
// (RL15) Power-down entry, then one no-operation
// (RL16) CKE stays high during writes and bursts
// (RL17) Device keeps rows in active power-down
// (RL18) CKE held low at least minimum time
// (RL19) Power-down time limited by refresh needs; not enforced here, refresh timing is left to the user
// (RL20) Exit with chip select high, CKE held
// (RL21) Wait exit latency before next command
// (RL22) Two stable clocks before leaving power-down
// (RL23) Programmable counters block new commands
module mrw_ctrl
  import mrw_ctrl_pkg::*;
(
  input  wire logic                                clock_in,
  input  wire logic                                rst_in,
  // User request port
  input  wire logic                                req_valid_in,
  input  wire mrw_ctrl_pkg::req_kind_e             req_kind_in,
  input  wire logic [mrw_ctrl_pkg::MA_W-1:0]       req_addr_in,
  input  wire logic [mrw_ctrl_pkg::OP_W-1:0]       req_data_in,
  input  wire logic                                banks_idle_in,
  input  wire logic                                burst_busy_in,
  output logic                                     req_ready_out,
  output logic                                     req_refused_out,
  output logic                                     done_out,
  output logic                                     powered_down_out,
  // Shared calibration resistor arbitration
  output logic                                     zq_claim_out,
  input  wire logic                                zq_grant_in,
  // Timing counts
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_mrw_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_zqinit_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_zqcl_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_zqcs_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_zqreset_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_init4_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_cke_in,
  input  wire logic [mrw_ctrl_pkg::CNT_W-1:0]      t_xp_in,
  // Memory pins
  output logic                                     ck_out,
  output logic                                     cke_out,
  output logic                                     cs_n_out,
  output logic [mrw_ctrl_pkg::CA_W-1:0]            ca_out,
  output logic                                     dq_quiet_out
);
  import mrw_ctrl_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE,
    S_CMD_R,
    S_CMD_F,
    S_WAIT,
    S_PD_ENTER,
    S_PD_NOP,
    S_PD_HOLD,
    S_PD,
    S_PD_PRECLK,
    S_PD_EXIT
  } state_e;

  typedef struct packed {
    state_e           state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] wait_len;
    logic [MA_W-1:0]  addr;
    logic [OP_W-1:0]  data;
    logic             zq_long;
    logic             cke;
    logic             cs_n;
    logic [CA_W-1:0]  ca;
    logic             quiet;
    logic             claim;
    logic             done;
    logic             refused;
  } st_s;

  // Registered state and its next value
  st_s st_q;
  st_s st_d;

  ck_if ck ();

  // Stop the link clock only while it is low, so no clipped high phase reaches the device
  assign ck.run = (st_q.state != S_PD) || ck_out; // see (RL19) see (RL22)

  // Rising edge pattern: CS low, CA3..CA0 low, MA5..MA0 on CA9..CA4
  function automatic logic [CA_W-1:0] ca_rise(input logic [MA_W-1:0] ma);
    ca_rise = {ma[5:0], 4'h0}; // see (RL1) see (RL2)
  endfunction

  // Falling edge pattern: OP7..OP0 on CA9..CA2, MA7..MA6 on CA1..CA0
  function automatic logic [CA_W-1:0] ca_fall(input logic [MA_W-1:0] ma, input logic [OP_W-1:0] op);
    ca_fall = {op, ma[7:6]}; // see (RL2)
  endfunction

  // Counter lengths per request kind
  function automatic logic [CNT_W-1:0] len_of(input req_kind_e k);
    case (k)
      REQ_MRW:       len_of = t_mrw_in;
      REQ_MRW_RESET: len_of = t_init4_in;
      REQ_ZQ_INIT:   len_of = t_zqinit_in;
      REQ_ZQ_LONG:   len_of = t_zqcl_in;
      REQ_ZQ_SHORT:  len_of = t_zqcs_in;
      REQ_ZQ_RESET:  len_of = t_zqreset_in;
      default:       len_of = t_mrw_in;
    endcase
  endfunction

  // Calibration codes that need the shared resistor and a quiet bus
  function automatic logic zq_needs_quiet(input req_kind_e k);
    zq_needs_quiet = (k == REQ_ZQ_INIT) || (k == REQ_ZQ_LONG) || (k == REQ_ZQ_SHORT);
  endfunction

  // Operand code for each calibration kind
  function automatic logic [OP_W-1:0] zq_code(input req_kind_e k);
    case (k)
      REQ_ZQ_INIT:  zq_code = ZQ_OP_INIT;
      REQ_ZQ_LONG:  zq_code = ZQ_OP_LONG;
      REQ_ZQ_SHORT: zq_code = ZQ_OP_SHORT;
      default:      zq_code = ZQ_OP_RESET;
    endcase
  endfunction

  // Down-counter helpers shared by every timed wait
  function automatic logic cnt_left(input logic [CNT_W-1:0] c);
    cnt_left = c != '0;
  endfunction

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    count_down = c - {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  // Two flip-flops on the shared resistor grant, it comes from another block
  logic grant_s1_q;
  logic grant_s2_q;

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      grant_s1_q <= 1'b0;
      grant_s2_q <= 1'b0;
    end else begin
      grant_s1_q <= zq_grant_in;
      grant_s2_q <= grant_s1_q;
    end
  end

  // Request decode
  logic      is_cmd;
  logic      ok_idle;
  req_kind_e kind;

  assign kind    = req_kind_in;
  assign is_cmd  = kind != REQ_PD_ENTER && kind != REQ_PD_EXIT;
  assign ok_idle = banks_idle_in && !burst_busy_in;

  // Request acceptance, only in a state that takes one
  always_comb begin
    req_ready_out = 1'b0;
    case (st_q.state)
      S_IDLE: begin
        if (is_cmd) begin
          req_ready_out = ok_idle && (!zq_needs_quiet(kind) || grant_s2_q); // see (RL4) see (RL9) see (RL12)
        end else if (kind == REQ_PD_ENTER) begin
          req_ready_out = !burst_busy_in; // see (RL16)
        end
      end
      S_PD: req_ready_out = kind == REQ_PD_EXIT;
      default: req_ready_out = 1'b0; // see (RL23)
    endcase
  end

  // Main sequencer
  always_comb begin
    st_d         = st_q;
    st_d.done    = 1'b0;
    st_d.refused = 1'b0;
    case (st_q.state)
      // Idle: chip select high, take the next request
      S_IDLE: begin
        st_d.cs_n = 1'b1;
        st_d.claim = 1'b0;
        if (req_valid_in && !req_ready_out) begin
          st_d.refused = 1'b1;
        end
        if (req_valid_in && req_ready_out) begin
          if (kind == REQ_PD_ENTER) begin
            st_d.state = S_PD_ENTER;
          end else begin
            st_d.state    = S_CMD_R;
            st_d.wait_len = len_of(kind);
            st_d.zq_long  = zq_needs_quiet(kind);
            st_d.claim    = zq_needs_quiet(kind);
            st_d.quiet    = zq_needs_quiet(kind); // see (RL10)
            case (kind)
              REQ_MRW: begin
                st_d.addr = req_addr_in;
                st_d.data = req_data_in;
              end
              REQ_MRW_RESET: begin
                st_d.addr = MA_RESET; // see (RL7)
                st_d.data = '0;
              end
              default: begin
                st_d.addr = MA_ZQ_CAL; // see (RL8)
                st_d.data = zq_code(kind);
              end
            endcase
          end
        end
      end
      // Drive on the rising link edge
      S_CMD_R: begin
        if (ck.rise) begin
          st_d.cs_n  = 1'b0;
          st_d.ca    = ca_rise(st_q.addr); // see (RL1)
          st_d.state = S_CMD_F;
        end
      end
      // Drive on the falling link edge
      S_CMD_F: begin
        if (ck.fall) begin
          st_d.ca    = ca_fall(st_q.addr, st_q.data); // see (RL2)
          st_d.quiet = st_q.zq_long; // see (RL10)
          st_d.state = S_WAIT;
          st_d.cnt   = st_q.wait_len;
        end
      end
      // No-operation with CS high while the period counts down
      S_WAIT: begin
        if (ck.rise) begin
          st_d.cs_n = 1'b1; // see (RL5) see (RL11)
        end
        if (cnt_left(st_q.cnt)) begin
          st_d.cnt = count_down(st_q.cnt); // see (RL23)
        end else if (st_q.cs_n) begin
          st_d.quiet = 1'b0;
          st_d.claim = 1'b0; // see (RL12)
          st_d.done  = 1'b1;
          st_d.state = S_IDLE;
        end
      end
      // CKE low with CS high on a rising edge
      // Held off while a burst runs, should one start after acceptance
      S_PD_ENTER: begin
        if (ck.rise && !burst_busy_in) begin // see (RL16)
          st_d.cke   = 1'b0; // see (RL15)
          st_d.cs_n  = 1'b1;
          st_d.state = S_PD_NOP;
        end
      end
      // One full link cycle of no-operation after entry
      S_PD_NOP: begin
        if (ck.rise) begin
          st_d.state = S_PD_HOLD;
          st_d.cnt   = t_cke_in;
        end
      end
      // CKE low held for its minimum before reporting entry
      S_PD_HOLD: begin
        if (cnt_left(st_q.cnt)) begin
          st_d.cnt = count_down(st_q.cnt); // see (RL18)
        end else begin
          st_d.done  = 1'b1;
          st_d.state = S_PD;
        end
      end
      // Clock stopped to save power; refresh timing is the user's job
      S_PD: begin
        if (req_valid_in && req_ready_out) begin
          st_d.state = S_PD_PRECLK;
          st_d.cnt   = DEF_CLKPRE;
        end
      end
      // Stable clocks before CKE rises
      S_PD_PRECLK: begin
        if (ck.rise) begin
          if (cnt_left(st_q.cnt)) begin
            st_d.cnt = count_down(st_q.cnt); // see (RL22)
          end else begin
            st_d.cke   = 1'b1; // see (RL20)
            st_d.cs_n  = 1'b1;
            st_d.state = S_PD_EXIT;
            st_d.cnt   = (t_xp_in > t_cke_in) ? t_xp_in : t_cke_in;
          end
        end
      end
      // Exit latency or CKE minimum, whichever is longer
      S_PD_EXIT: begin
        if (cnt_left(st_q.cnt)) begin
          st_d.cnt = count_down(st_q.cnt); // see (RL21)
        end else begin
          st_d.done  = 1'b1;
          st_d.state = S_IDLE;
        end
      end
      default: st_d.state = S_IDLE;
    endcase
  end

  // State register; pins come up with CKE high and chip select idle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_q       <= '0;
      st_q.state <= S_IDLE;
      st_q.cke   <= 1'b1;
      st_q.cs_n  <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  ck_gen u_ck_gen (
    .clock_in (clock_in),
    .rst_in   (rst_in),
    .ck       (ck.gen),
    .ck_out   (ck_out)
  );

  // Pins and status straight from flip-flops
  assign cke_out          = st_q.cke;
  assign cs_n_out         = st_q.cs_n;
  assign ca_out           = st_q.ca;
  assign dq_quiet_out     = st_q.quiet;
  assign zq_claim_out     = st_q.claim;
  assign done_out         = st_q.done;
  assign req_refused_out  = st_q.refused;
  assign powered_down_out = !st_q.cke;
endmodule
`default_nettype wire

// ### mrw_ctrl_pkg.sv
package mrw_ctrl_pkg;

  // Command/address bus
  localparam int CA_W   = 10;
  localparam int MA_W   = 8;
  localparam int OP_W   = 8;

  // Calibration and reset register addresses, calibration command codes
  localparam logic [7:0] MA_ZQ_CAL   = 8'h0a;
  localparam logic [7:0] MA_RESET    = 8'h3f;
  localparam logic [7:0] ZQ_OP_INIT  = 8'hff;
  localparam logic [7:0] ZQ_OP_LONG  = 8'hab;
  localparam logic [7:0] ZQ_OP_SHORT = 8'h56;
  localparam logic [7:0] ZQ_OP_RESET = 8'hc3;

  // Programmable cycle counters are this wide
  localparam int CNT_W = 20;

  // Default timing counts, in controller clock cycles at 250 MHz; DEF_CLKPRE counts link clock rises
  localparam logic [CNT_W-1:0] DEF_MRW     = 20'h00005;
  localparam logic [CNT_W-1:0] DEF_ZQINIT  = 20'h3d090;
  localparam logic [CNT_W-1:0] DEF_ZQCL    = 20'h00168;
  localparam logic [CNT_W-1:0] DEF_ZQCS    = 20'h0005a;
  localparam logic [CNT_W-1:0] DEF_ZQRESET = 20'h00032;
  localparam logic [CNT_W-1:0] DEF_INIT4   = 20'h00000;
  localparam logic [CNT_W-1:0] DEF_CKE     = 20'h00003;
  localparam logic [CNT_W-1:0] DEF_XP      = 20'h00003;
  localparam logic [CNT_W-1:0] DEF_CLKPRE  = 20'h00002;

  // Link clock divider: half period in controller cycles
  localparam logic [3:0] CK_HALF = 4'h4;

  // Request kinds from the user side
  typedef enum logic [2:0] {
    REQ_MRW,
    REQ_MRW_RESET,
    REQ_ZQ_INIT,
    REQ_ZQ_LONG,
    REQ_ZQ_SHORT,
    REQ_ZQ_RESET,
    REQ_PD_ENTER,
    REQ_PD_EXIT
  } req_kind_e;

endpackage

// ### mrw_ctrl_properties.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of the mode write, calibration and power-down sequencing
module mrw_ctrl_properties
  import mrw_ctrl_pkg::*;
(
  input wire logic                             clock_in,
  input wire logic                             rst_in,
  input wire logic                             req_valid_in,
  input wire mrw_ctrl_pkg::req_kind_e          req_kind_in,
  input wire logic                             req_ready_out,
  input wire logic                             banks_idle_in,
  input wire logic                             burst_busy_in,
  input wire logic                             done_out,
  input wire logic                             zq_claim_out,
  input wire logic [mrw_ctrl_pkg::CNT_W-1:0]   t_cke_in,
  input wire logic                             cke_out,
  input wire logic                             cs_n_out,
  input wire logic [mrw_ctrl_pkg::CA_W-1:0]    ca_out,
  input wire logic                             dq_quiet_out
);
  import mrw_ctrl_pkg::*;
  logic [CNT_W-1:0] low_cnt_q;

  // Length of the current CKE low stretch, so the minimum pulse can be judged
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      low_cnt_q <= 20'h00000;
    end else begin
      low_cnt_q <= cke_out ? 20'h00000 : low_cnt_q + 20'h00001;
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  // Request accepted, and the short command strobe
  sequence taken_s;
    req_valid_in && req_ready_out;
  endsequence
  sequence cmd_low_s;
    !cs_n_out [*4];
  endsequence

  AST_MRW_PATTERN: assert property (
    $fell(cs_n_out) |-> cke_out && ca_out[3:0] == 4'h0) else $error("command strobe without mode write code");
  AST_MRW_SINGLE: assert property (
    $fell(cs_n_out) |-> cmd_low_s ##[1:8] cs_n_out) else $error("command strobe length wrong");
  AST_IDLE_ONLY: assert property (
    taken_s ##0 (req_kind_in inside {REQ_MRW, REQ_MRW_RESET, REQ_ZQ_INIT, REQ_ZQ_LONG, REQ_ZQ_SHORT, REQ_ZQ_RESET})
    |-> banks_idle_in && !burst_busy_in) else $error("mode write taken with banks busy");
  AST_ZQ_CLAIM: assert property (
    taken_s ##0 (req_kind_in inside {REQ_ZQ_INIT, REQ_ZQ_LONG, REQ_ZQ_SHORT}) |=> zq_claim_out)
    else $error("calibration started without resistor claim");
  AST_CAL_QUIET: assert property (
    zq_claim_out |-> cke_out && dq_quiet_out) else $error("calibration without CKE high and quiet bus");
  AST_PD_ENTRY: assert property (
    $fell(cke_out) |-> cs_n_out ##1 cs_n_out) else $error("power-down entry without no-operation");
  AST_PD_EXIT: assert property (
    $rose(cke_out) |-> cs_n_out) else $error("power-down exit with chip select low");
  AST_CKE_MIN: assert property (
    $rose(cke_out) |-> low_cnt_q >= t_cke_in) else $error("CKE low pulse too short");
  AST_CKE_BURST: assert property (
    burst_busy_in && cke_out |=> cke_out) else $error("CKE lowered during a burst");
  AST_PD_DONE: assert property (
    $fell(cke_out) |-> ##[1:64] done_out) else $error("power-down entry never completed");
endmodule

bind mrw_ctrl mrw_ctrl_properties u_props (
  .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
  .req_ready_out(req_ready_out), .banks_idle_in(banks_idle_in), .burst_busy_in(burst_busy_in),
  .done_out(done_out), .zq_claim_out(zq_claim_out), .t_cke_in(t_cke_in), .cke_out(cke_out),
  .cs_n_out(cs_n_out), .ca_out(ca_out), .dq_quiet_out(dq_quiet_out)
);
`default_nettype wire

// ### tb_mrw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_mrw_ctrl;
  import mrw_ctrl_pkg::*;
  logic             clock_in, rst_in, req_valid_in, banks_idle_in, burst_busy_in, zq_grant_in;
  req_kind_e        req_kind_in;
  logic [7:0]       req_addr_in, req_data_in;
  logic             req_ready_out, req_refused_out, done_out, powered_down_out, zq_claim_out;
  logic             ck_out, cke_out, cs_n_out, dq_quiet_out, cmd_tgl, pd, pd_act, zq_on;
  logic [9:0]       ca_out;
  logic [15:0]      cmd;
  logic [CNT_W-1:0] t_mrw, t_zqi, t_zql, t_zqs, t_zqr, t_init4, t_cke, t_xp;
  logic [16:0]      notes [$];
  logic [16:0]      n;
  int               fail_count, samples_checked;

  mrw_ctrl u_mrw_ctrl (
    .clock_in(clock_in), .rst_in(rst_in), .req_valid_in(req_valid_in), .req_kind_in(req_kind_in),
    .req_addr_in(req_addr_in), .req_data_in(req_data_in), .banks_idle_in(banks_idle_in),
    .burst_busy_in(burst_busy_in), .req_ready_out(req_ready_out), .req_refused_out(req_refused_out),
    .done_out(done_out), .powered_down_out(powered_down_out), .zq_claim_out(zq_claim_out),
    .zq_grant_in(zq_grant_in), .t_mrw_in(t_mrw), .t_zqinit_in(t_zqi), .t_zqcl_in(t_zql),
    .t_zqcs_in(t_zqs), .t_zqreset_in(t_zqr), .t_init4_in(t_init4), .t_cke_in(t_cke), .t_xp_in(t_xp),
    .ck_out(ck_out), .cke_out(cke_out), .cs_n_out(cs_n_out), .ca_out(ca_out), .dq_quiet_out(dq_quiet_out));

  mem_dev_model u_mem_dev_model (
    .ck_in(ck_out), .cke_in(cke_out), .cs_n_in(cs_n_out), .ca_in(ca_out), .banks_idle_in(banks_idle_in),
    .cmd_out(cmd), .cmd_tgl_out(cmd_tgl), .pd_out(pd), .pd_active_out(pd_act), .zq_on_out(zq_on));

  // Controller clock, 4 ns
  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Bounded wait for done (sel high) or ready (sel low) at the rising edge; a hang ends the run
  task automatic wait_high(input bit sel, input int lim);
    int   w;
    logic s;
    w = 0;
    s = 1'b0;
    do begin
      @(posedge clock_in);
      w++;
      s = sel ? done_out : req_ready_out;
    end while (s !== 1'b1 && w < lim);
    if (s !== 1'b1) begin
      check(16'hdead, 16'h0000);
      close_out();
    end
  endtask

  // One full request: note the expected device command, hold valid until taken, await completion
  task automatic issue(input req_kind_e k, input logic [7:0] a, input logic [7:0] d);
    logic q;
    q = k inside {REQ_ZQ_INIT, REQ_ZQ_LONG, REQ_ZQ_SHORT};
    case (k)
      REQ_MRW:       notes.push_back({1'b1, a, d});
      REQ_MRW_RESET: notes.push_back({1'b0, MA_RESET, 8'h00});
      REQ_ZQ_INIT:   notes.push_back({1'b1, MA_ZQ_CAL, ZQ_OP_INIT});
      REQ_ZQ_LONG:   notes.push_back({1'b1, MA_ZQ_CAL, ZQ_OP_LONG});
      REQ_ZQ_SHORT:  notes.push_back({1'b1, MA_ZQ_CAL, ZQ_OP_SHORT});
      REQ_ZQ_RESET:  notes.push_back({1'b1, MA_ZQ_CAL, ZQ_OP_RESET});
      default: ;
    endcase
    @(posedge clock_in);
    req_kind_in <= k;
    req_addr_in <= a;
    req_data_in <= d;
    req_valid_in <= 1'b1;
    wait_high(1'b0, 100);
    req_valid_in <= 1'b0;
    // Claim and quiet bus stand from acceptance of an init, long or short calibration kind only
    @(posedge clock_in);
    check({14'h0000, zq_claim_out, dq_quiet_out}, {14'h0000, q, q});
    wait_high(1'b1, 3000);
  endtask

  // Request that must be turned away: ready never high, a refusal pulse seen
  task automatic refuse(input req_kind_e k);
    logic r, f;
    r = 1'b0;
    f = 1'b0;
    @(posedge clock_in);
    req_kind_in <= k;
    req_valid_in <= 1'b1;
    repeat (4) begin
      @(posedge clock_in);
      r |= req_ready_out === 1'b1;
      f |= req_refused_out === 1'b1;
    end
    req_valid_in <= 1'b0;
    check({14'h0000, r, f}, 16'h0001);
  endtask

  // Each decoded device command answers the oldest note
  always @(cmd_tgl) begin
    if (rst_in === 1'b0) begin
      if (notes.size() == 0) begin
        check(cmd, 16'hffff);
      end else begin
        n = notes.pop_front();
        check(n[16] ? cmd : {cmd[15:8], 8'h00}, n[15:0]);
      end
    end
  end

  initial begin
    void'($urandom(2));
    {rst_in, req_valid_in, burst_busy_in, banks_idle_in, zq_grant_in} = 5'b10011;
    req_kind_in = REQ_MRW;
    {req_addr_in, req_data_in} = 16'h0000;
    fail_count = 0;
    samples_checked = 0;
    // Init calibration count shortened so the run stays brief
    t_mrw = DEF_MRW + 20'($urandom_range(0, 3));
    t_zqi = 20'h00064 + 20'($urandom_range(0, 15));
    {t_zql, t_zqs, t_zqr, t_init4} = {DEF_ZQCL, DEF_ZQCS, DEF_ZQRESET, DEF_INIT4};
    {t_cke, t_xp} = {DEF_CKE + 20'($urandom_range(0, 4)), DEF_XP};
    repeat (16) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    for (int i = 0; i < 5; i++) issue(REQ_MRW, 8'($urandom), 8'($urandom));
    $display("test 1 mode writes done");
    for (int k = 1; k < 6; k++) issue(req_kind_e'(k), 8'h00, 8'h00);
    $display("test 2 reset and calibrations done");
    for (int c = 0; c < 4; c++) begin
      @(posedge clock_in);
      case (c)
        0: banks_idle_in <= 1'b0;
        1: burst_busy_in <= 1'b1;
        2: burst_busy_in <= 1'b1;
        default: zq_grant_in <= 1'b0;
      endcase
      repeat (4) @(posedge clock_in);
      refuse(c == 0 ? REQ_MRW : c == 1 ? REQ_ZQ_SHORT : c == 2 ? REQ_PD_ENTER : REQ_ZQ_LONG);
      {banks_idle_in, burst_busy_in, zq_grant_in} <= 3'b101;
      repeat (4) @(posedge clock_in);
    end
    $display("test 3 refusals done");
    banks_idle_in <= 1'b0;
    issue(REQ_PD_ENTER, 8'h00, 8'h00);
    repeat (2) @(posedge clock_in);
    check({13'h0000, pd, pd_act, powered_down_out}, 16'h0007);
    repeat (40) @(posedge clock_in);
    issue(REQ_PD_EXIT, 8'h00, 8'h00);
    check({14'h0000, pd, powered_down_out}, 16'h0000);
    banks_idle_in <= 1'b1;
    issue(REQ_MRW, 8'h3e, 8'h5a);
    issue(REQ_ZQ_SHORT, 8'h00, 8'h00);
    $display("test 4 power-down done");
    repeat (40) @(posedge clock_in);
    check(16'(notes.size()), 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
